// ### bench/lisc_top_props.sv
// lisc_top_props: concurrent checks on the shaping configuration ports.
// assumes: bound to lisc_top; one clock ref_clk, async active-low rstn.
`timescale 1ns/100ps

module lisc_top_props #(
  parameter int SLOT_CYCLES = 6  // must match the bound design
) (
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire logic                    up_cs_n,
  input wire logic                    up_rd_n,
  input wire logic                    up_wr_n,
  input wire logic [4:0]              up_addr,
  input wire logic [7:0]              up_wdata,
  input wire logic [7:0]              up_rdata,
  input wire logic                    up_data_oe,
  input wire logic                    eq_auto_en,
  input wire lisc_pkg::lisc_eq_mode_t eq_mode,
  input wire logic [4:0]              eq_gain_db,
  input wire lisc_pkg::lisc_slot_t    tx_slot,
  input wire logic                    tx_cell_start,
  input wire logic                    tx_pulse_sign,
  input wire logic [5:0]              tx_pulse_mag,
  input wire logic signed [13:0]      tx_pulse_mv
);
  // ==========================================================
  // helper: slot change and dwell tracking
  lisc_pkg::lisc_slot_t slot_prev_q;  // slot one cycle ago
  logic [7:0]           dwell_q;      // cycles since last change
  logic                 seen_q;       // first dwell after reset is longer
  logic                 chg;          // slot moved this cycle
  assign chg = (tx_slot != slot_prev_q);

  // count cycles per slot
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_prev_q <= lisc_pkg::LISC_SLOT_FOUR;
      dwell_q     <= 8'h00;
      seen_q      <= 1'b0;
    end else begin
      slot_prev_q <= tx_slot;
      dwell_q     <= chg ? 8'h00 : dwell_q + 8'h01;
      seen_q      <= seen_q | chg;
    end
  end

  // walking order of the four slots
  function automatic lisc_pkg::lisc_slot_t nxt(input lisc_pkg::lisc_slot_t s);
    case (s)
      lisc_pkg::LISC_SLOT_ONE:   return lisc_pkg::LISC_SLOT_TWO;
      lisc_pkg::LISC_SLOT_TWO:   return lisc_pkg::LISC_SLOT_THREE;
      lisc_pkg::LISC_SLOT_THREE: return lisc_pkg::LISC_SLOT_FOUR;
      default:                   return lisc_pkg::LISC_SLOT_ONE;
    endcase
  endfunction : nxt

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // equalizer mode and gain
  a_eq_auto_lvl: assert property (eq_auto_en == (eq_mode == lisc_pkg::LISC_EQ_AUTO))
    else $error("auto enable disagrees with mode");
  a_gain_single: assert property (
    eq_mode == lisc_pkg::LISC_EQ_SINGLE |-> eq_gain_db == 5'h06)
    else $error("single stage gain wrong");
  a_gain_double: assert property (
    eq_mode == lisc_pkg::LISC_EQ_DOUBLE |-> eq_gain_db == 5'h0c)
    else $error("double stage gain wrong");
  a_gain_none: assert property (
    eq_mode inside {lisc_pkg::LISC_EQ_AUTO, lisc_pkg::LISC_EQ_OFF} |-> eq_gain_db == 5'h00)
    else $error("forced gain outside forced modes");
  a_eq_at_cell: assert property (!$stable(eq_mode) |-> $past(tx_cell_start))
    else $error("equalizer mode moved off a cell boundary");

  // ==========================================================
  // pulse amplitude and slot walk
  a_mv_pos: assert property (tx_pulse_sign |-> tx_pulse_mv == 14'(tx_pulse_mag * 100))
    else $error("positive amplitude wrong");
  a_mv_neg: assert property (
    !tx_pulse_sign |-> tx_pulse_mv == 14'(0 - tx_pulse_mag * 100))
    else $error("negative amplitude wrong");
  a_slot_dwell: assert property (chg && seen_q |-> dwell_q == 8'(SLOT_CYCLES - 1))
    else $error("slot dwell wrong");
  a_slot_order: assert property (chg |-> tx_slot == nxt(slot_prev_q))
    else $error("slot order wrong");
  a_cell_start: assert property (
    tx_cell_start == (chg && tx_slot == lisc_pkg::LISC_SLOT_ONE))
    else $error("cell start not at slot one");

  // ==========================================================
  // read drive on the data bus
  sequence s_read_held;
    (!up_cs_n && !up_rd_n) [*4];
  endsequence
  a_read_oe: assert property (s_read_held |-> up_data_oe)
    else $error("read strobe without drive");
  a_oe_cause: assert property ($rose(up_data_oe) |-> $past(!up_cs_n && !up_rd_n, 3))
    else $error("drive without read strobe");
endmodule : lisc_top_props

bind lisc_top lisc_top_props #(.SLOT_CYCLES(SLOT_CYCLES)) i_props (
  .ref_clk(ref_clk), .rstn(rstn), .up_cs_n(up_cs_n), .up_rd_n(up_rd_n),
  .up_wr_n(up_wr_n), .up_addr(up_addr), .up_wdata(up_wdata),
  .up_rdata(up_rdata), .up_data_oe(up_data_oe), .eq_auto_en(eq_auto_en),
  .eq_mode(eq_mode), .eq_gain_db(eq_gain_db), .tx_slot(tx_slot),
  .tx_cell_start(tx_cell_start), .tx_pulse_sign(tx_pulse_sign),
  .tx_pulse_mag(tx_pulse_mag), .tx_pulse_mv(tx_pulse_mv));

// ### bench/test_line_interface_shaping_config.sv
// test_line_interface_shaping_config: random and corner register traffic.
// assumes: lisc_top with a short slot count; checker bound in its own file.
`timescale 1ns/100ps
`include "lisc_regs.svh"

module test_line_interface_shaping_config;
  localparam int SC = 3;  // short slot keeps cells quick
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] din = 8'h00;
  logic [7:0] dout;
  logic oe, auto_en, cstart, sign;
  lisc_pkg::lisc_eq_mode_t mode;
  lisc_pkg::lisc_slot_t slot;
  logic [4:0] gain;
  logic [5:0] mag;
  logic signed [13:0] mv;
  int fails = 0;
  int checks_done = 0;

  always #10 ref_clk = ~ref_clk;

  lisc_top #(.SLOT_CYCLES(SC)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .up_cs_n(cs_n), .up_rd_n(rd_n), .up_wr_n(wr_n),
    .up_addr(addr), .up_wdata(din), .up_rdata(dout), .up_data_oe(oe),
    .eq_auto_en(auto_en), .eq_mode(mode), .eq_gain_db(gain), .tx_slot(slot),
    .tx_cell_start(cstart), .tx_pulse_sign(sign), .tx_pulse_mag(mag), .tx_pulse_mv(mv));

  // ==========================================================
  // bench helpers
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // inputs always move 2 ns after the edge
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick

  // write strobe held 4 cycles, data held past release
  task wr(input logic [4:0] a, input logic [7:0] d, input logic sel);
    tick(1);
    cs_n = ~sel;
    wr_n = 1'b0;
    addr = a;
    din = d;
    tick(4);
    wr_n = 1'b1;
    cs_n = 1'b1;
    tick(5);
  endtask : wr

  task rd_chk(input logic [4:0] a, input logic [7:0] exp);
    tick(1);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    tick(5);
    check({oe, dout}, {1'b1, exp});
    rd_n = 1'b1;
    cs_n = 1'b1;
    tick(5);
  endtask : rd_chk

  // bounded wait for the next cell start
  task to_cell;
    tick(1);
    for (int n = 0; n < 40 && cstart !== 1'b1; n++) tick(1);
    check(cstart, 1'b1);
  endtask : to_cell

  function automatic logic [7:0] eq_exp(input logic [7:0] v);
    if (!v[7]) return {1'b1, lisc_pkg::LISC_EQ_AUTO, 5'h00};
    if (v[6]) return {1'b0, lisc_pkg::LISC_EQ_SINGLE, 5'h06};
    if (v[5]) return {1'b0, lisc_pkg::LISC_EQ_DOUBLE, 5'h0c};
    return {1'b0, lisc_pkg::LISC_EQ_OFF, 5'h00};
  endfunction : eq_exp

  function automatic logic [20:0] pl_exp(input logic [7:0] v);
    logic [13:0] m;
    m = 14'(v[5:0] * 100);
    return {v[6], v[5:0], v[6] ? m : 14'(0 - m)};
  endfunction : pl_exp

  // ==========================================================
  // main sequence
  logic [4:0] ofs [4] = '{`LISC_OFS_PULSE_ONE, `LISC_OFS_PULSE_TWO,
                          `LISC_OFS_PULSE_THREE, `LISC_OFS_PULSE_FOUR};
  lisc_pkg::lisc_slot_t so [4] = '{lisc_pkg::LISC_SLOT_ONE, lisc_pkg::LISC_SLOT_TWO,
                                   lisc_pkg::LISC_SLOT_THREE, lisc_pkg::LISC_SLOT_FOUR};
  logic [7:0] corner [4] = '{8'h7f, 8'h00, 8'h40, 8'hbf};  // max, zero, +0, -max
  logic [4:0] hole [4] = '{5'h00, 5'h18, 5'h1a, 5'h1b};      // unmapped places
  logic [7:0] pv [4];
  logic [7:0] v;

  initial begin
    void'($urandom(32'h9538));
    repeat (16) @(posedge ref_clk);
    #2 rstn = 1'b1;
    // reset values of every register
    foreach (ofs[k]) rd_chk(ofs[k], 8'h00);
    rd_chk(`LISC_OFS_RX_EQ, 8'h00);
    check({auto_en, mode, gain}, eq_exp(8'h00));
    $display("test reset values done");
    // every equalizer code, then random ones
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? {i[2:0], 5'($urandom)} : 8'($urandom);
      wr(`LISC_OFS_RX_EQ, v, 1'b1);
      rd_chk(`LISC_OFS_RX_EQ, v & `LISC_MASK_RX_EQ);
      to_cell;
      to_cell;
      check({auto_en, mode, gain}, eq_exp(v));
    end
    $display("test equalizer modes done");
    // corner pulse shapes first, random after
    for (int r = 0; r < 6; r++) begin
      foreach (ofs[k]) begin
        pv[k] = (r == 0) ? corner[k] : 8'($urandom);
        wr(ofs[k], pv[k], 1'b1);
      end
      foreach (ofs[k]) rd_chk(ofs[k], pv[k] & `LISC_MASK_PULSE);
      to_cell;
      to_cell;
      foreach (ofs[k]) begin
        tick(1);
        check(slot, so[k]);
        check({sign, mag, mv}, pl_exp(pv[k]));
        tick(SC - 1);
      end
    end
    $display("test pulse shapes done");
    // unmapped writes and deselected writes change nothing
    foreach (hole[k]) wr(hole[k], 8'($urandom), 1'b1);
    wr(ofs[0], ~pv[0], 1'b0);
    foreach (hole[k]) rd_chk(hole[k], 8'h00);
    rd_chk(ofs[0], pv[0] & `LISC_MASK_PULSE);
    $display("test refused writes done");
    // second reset in mid-run clears the registers
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    rd_chk(`LISC_OFS_RX_EQ, 8'h00);
    rd_chk(ofs[3], 8'h00);
    $display("test second reset done");
    wrap_up();
  end

  // about 1500 cycles expected; 1 ms leaves wide margin
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule : test_line_interface_shaping_config

// ### rtl/lisc_pkg.sv
// lisc_pkg: types shared by the shaping configuration block.
// assumes: referenced as lisc_pkg::name, never imported.
package lisc_pkg;

  // ==========================================================
  // receive equalizer operating mode
  typedef enum logic [1:0] {
    LISC_EQ_AUTO   = 2'h0,  // automatic loop-length compensation
    LISC_EQ_OFF    = 2'h1,  // auto disabled, no forced stage
    LISC_EQ_SINGLE = 2'h2,  // one forced stage
    LISC_EQ_DOUBLE = 2'h3   // two forced stages
  } lisc_eq_mode_t;

  // ==========================================================
  // time slot within one bit cell, gray order along the sequence
  typedef enum logic [1:0] {
    LISC_SLOT_ONE   = 2'b00,
    LISC_SLOT_TWO   = 2'b01,
    LISC_SLOT_THREE = 2'b11,
    LISC_SLOT_FOUR  = 2'b10
  } lisc_slot_t;

endpackage : lisc_pkg

// ### rtl/lisc_regs.svh
// lisc_regs.svh: offsets, field positions, reset values and timing counts
// for the line interface shaping configuration block.
// assumes: included by bare name from design files; definitions only.
`ifndef LISC_REGS_SVH
`define LISC_REGS_SVH

// ==========================================================
// register offsets on the parallel port (5-bit address)
`define LISC_OFS_RX_EQ        5'h19
`define LISC_OFS_PULSE_ONE    5'h1c
`define LISC_OFS_PULSE_TWO    5'h1d
`define LISC_OFS_PULSE_THREE  5'h1e
`define LISC_OFS_PULSE_FOUR   5'h1f

// ==========================================================
// field positions
`define LISC_EQ_AUTO_DIS_BIT  7
`define LISC_EQ_SINGLE_BIT    6
`define LISC_EQ_DOUBLE_BIT    5
`define LISC_PULSE_SIGN_BIT   6
`define LISC_PULSE_MAG_MSB    5
`define LISC_PULSE_MAG_LSB    0

// ==========================================================
// reset values and read masks
`define LISC_RST_RX_EQ        8'h00
`define LISC_RST_PULSE        8'h00
`define LISC_MASK_RX_EQ       8'he0
`define LISC_MASK_PULSE       8'h7f
`define LISC_READ_UNMAPPED    8'h00

// ==========================================================
// amplitude scale and gains
`define LISC_MV_PER_COUNT     14'h0064
`define LISC_GAIN_SINGLE_DB   5'h06
`define LISC_GAIN_DOUBLE_DB   5'h0c
`define LISC_GAIN_NONE_DB     5'h00

// ==========================================================
// timing: clock period, bit cell, slots per cell
`define LISC_CLK_PERIOD_NS    20
`define LISC_BIT_CELL_NS      488
`define LISC_SLOTS_PER_CELL   4
// longest slot time rounds down, never below one cycle
`define LISC_SLOT_CYCLES \
  (((`LISC_BIT_CELL_NS / (`LISC_SLOTS_PER_CELL * `LISC_CLK_PERIOD_NS)) < 1) ? 1 : \
   (`LISC_BIT_CELL_NS / (`LISC_SLOTS_PER_CELL * `LISC_CLK_PERIOD_NS)))

`endif

// ### rtl/lisc_slot_if.sv
// lisc_slot_if: slot timing carried from the sequencer to the register bank.
// assumes: one clock domain, ref_clk.
`timescale 1ns/100ps

interface lisc_slot_if;
  lisc_pkg::lisc_slot_t slot;        // current slot of the bit cell
  logic                 slot_strobe; // one-cycle pulse at every slot start
  logic                 cell_start;  // one-cycle pulse at first slot start

  modport seq (output slot, output slot_strobe, output cell_start);
  modport bank (input slot, input slot_strobe, input cell_start);
endinterface : lisc_slot_if

// ### rtl/lisc_slot_seq.sv
// lisc_slot_seq: divides ref_clk into slot enables and walks four slots.
// assumes: ref_clk at 50 MHz, rstn asynchronous active low.
`timescale 1ns/100ps
`include "lisc_regs.svh"

module lisc_slot_seq #(
  parameter int SLOT_CYCLES = `LISC_SLOT_CYCLES  // clock cycles per slot
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  lisc_slot_if.seq  sif
);

  localparam int CW = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
  localparam logic [CW-1:0] DIV_LAST = CW'(SLOT_CYCLES - 1);

  logic [CW-1:0]        div_q;   // slot divider
  logic                 tick;    // end of the current slot
  lisc_pkg::lisc_slot_t slot_q;  // slot state

  assign tick = (div_q == DIV_LAST);

  // ==========================================================
  // divider: one enable per slot
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CW'(1);
    end
  end

  // ==========================================================
  // RULE7: slot walk order
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_q <= lisc_pkg::LISC_SLOT_FOUR;
    end else if (tick) begin
      case (slot_q)
        lisc_pkg::LISC_SLOT_ONE:   slot_q <= lisc_pkg::LISC_SLOT_TWO;
        lisc_pkg::LISC_SLOT_TWO:   slot_q <= lisc_pkg::LISC_SLOT_THREE;
        lisc_pkg::LISC_SLOT_THREE: slot_q <= lisc_pkg::LISC_SLOT_FOUR;
        lisc_pkg::LISC_SLOT_FOUR:  slot_q <= lisc_pkg::LISC_SLOT_ONE;
        default:                   slot_q <= lisc_pkg::LISC_SLOT_ONE;
      endcase
    end
  end

  // strobes mark the first cycle of a new slot
  logic strobe_q;  // delayed tick, aligned with new slot value
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= tick;
    end
  end

  assign sif.slot        = slot_q;
  assign sif.slot_strobe = strobe_q;
  assign sif.cell_start  = strobe_q && (slot_q == lisc_pkg::LISC_SLOT_ONE);

endmodule : lisc_slot_seq

// ### rtl/lisc_top.sv
// lisc_top: receive equalizer mode and transmit pulse shape registers,
// reached over the parallel microprocessor port, with slot sequencing.
// assumes: port pins are asynchronous to ref_clk and held stable around
// the strobes for at least three clock cycles; analog parts lie outside.
//
// Function
// RULE1: auto-disable bit takes equalizer out of auto
// RULE2: clear auto-disable keeps automatic loop compensation
// RULE3: mid bit plus disable forces 6 dB
// RULE4: max, disable, not mid forces 12 dB
// RULE5: bit six one positive, zero negative
// RULE6: six-bit magnitude, 0.1 volt per count
// RULE7: four registers drive slots one to four
// RULE8: writes apply next cell, reads return written
`timescale 1ns/100ps
`include "lisc_regs.svh"

module lisc_top #(
  parameter int SLOT_CYCLES = `LISC_SLOT_CYCLES  // clock cycles per slot
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    up_cs_n,
  input  wire logic                    up_rd_n,
  input  wire logic                    up_wr_n,
  input  wire logic [4:0]              up_addr,
  input  wire logic [7:0]              up_wdata,
  output logic      [7:0]              up_rdata,
  output logic                         up_data_oe,
  output logic                         eq_auto_en,
  output lisc_pkg::lisc_eq_mode_t      eq_mode,
  output logic      [4:0]              eq_gain_db,
  output lisc_pkg::lisc_slot_t         tx_slot,
  output logic                         tx_cell_start,
  output logic                         tx_pulse_sign,
  output logic      [5:0]              tx_pulse_mag,
  output logic signed [13:0]           tx_pulse_mv
);

  // ==========================================================
  // pin synchronisers: three stages, first read only by second
  logic [15:0] pin_s1_q;  // raw capture
  logic [15:0] pin_s2_q;  // settled
  logic [15:0] pin_s3_q;  // one cycle older, for edge detection
  logic [15:0] pin_raw;   // packed pins

  assign pin_raw = {up_cs_n, up_rd_n, up_wr_n, up_addr, up_wdata};

  // pins idle high on strobes, zero elsewhere
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 16'he000;
      pin_s2_q <= 16'he000;
      pin_s3_q <= 16'he000;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic       cs_n_s;    // settled chip select
  logic       rd_n_s;    // settled read strobe
  logic       wr_n_s;    // settled write strobe
  logic       wr_n_old;  // write strobe one cycle older
  logic       cs_n_old;  // chip select one cycle older
  logic [4:0] addr_old;  // address held during the strobe
  logic [7:0] data_old;  // write data held during the strobe
  logic [4:0] addr_s;    // settled address for reads
  logic       wr_commit; // one-cycle pulse at end of a write

  assign cs_n_s   = pin_s2_q[15];
  assign rd_n_s   = pin_s2_q[14];
  assign wr_n_s   = pin_s2_q[13];
  assign addr_s   = pin_s2_q[12:8];
  assign cs_n_old = pin_s3_q[15];
  assign wr_n_old = pin_s3_q[13];
  assign addr_old = pin_s3_q[12:8];
  assign data_old = pin_s3_q[7:0];

  // write lands on the rising edge of the strobe, data taken from before it
  assign wr_commit = wr_n_s && !wr_n_old && !cs_n_old;

  // ==========================================================
  // host-visible registers
  logic [7:0] eq_reg_q;            // receive equalization control
  logic [7:0] pulse_reg_q [4];     // pulse levels, index 0 is slot one
  logic [4:0] pulse_ofs [4];       // offsets by slot index

  assign pulse_ofs[0] = `LISC_OFS_PULSE_ONE;
  assign pulse_ofs[1] = `LISC_OFS_PULSE_TWO;
  assign pulse_ofs[2] = `LISC_OFS_PULSE_THREE;
  assign pulse_ofs[3] = `LISC_OFS_PULSE_FOUR;

  // RULE8: store written value, unused bits dropped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eq_reg_q <= `LISC_RST_RX_EQ;
    end else if (wr_commit && (addr_old == `LISC_OFS_RX_EQ)) begin
      eq_reg_q <= data_old & `LISC_MASK_RX_EQ;
    end
  end

  // one register per slot; generate keeps the four identical
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pulse
      // RULE8: store written pulse level
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pulse_reg_q[gi] <= `LISC_RST_PULSE;
        end else if (wr_commit && (addr_old == pulse_ofs[gi])) begin
          pulse_reg_q[gi] <= data_old & `LISC_MASK_PULSE;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path: unmapped offsets answer zero
  logic [7:0] rd_mux;  // selected read value
  always_comb begin
    rd_mux = `LISC_READ_UNMAPPED;
    case (addr_s)
      `LISC_OFS_RX_EQ:       rd_mux = eq_reg_q;
      `LISC_OFS_PULSE_ONE:   rd_mux = pulse_reg_q[0];
      `LISC_OFS_PULSE_TWO:   rd_mux = pulse_reg_q[1];
      `LISC_OFS_PULSE_THREE: rd_mux = pulse_reg_q[2];
      `LISC_OFS_PULSE_FOUR:  rd_mux = pulse_reg_q[3];
      default:               rd_mux = `LISC_READ_UNMAPPED;
    endcase
  end

  // RULE8: read back last written value
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      up_rdata    <= 8'h00;
      up_data_oe  <= 1'b0;
    end else begin
      up_rdata    <= rd_mux;
      up_data_oe  <= !cs_n_s && !rd_n_s;
    end
  end

  // ==========================================================
  // slot sequencer
  lisc_slot_if sif ();

  lisc_slot_seq #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_seq (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sif     (sif)
  );

  // ==========================================================
  // active copies, swapped in only at a bit cell boundary, at the end of the first
  // cycle of slot one, which still drives the old slot-one level
  logic [7:0] eq_act_q;         // equalizer setting in force
  logic [6:0] pulse_act_q [4];  // pulse levels in force

  // RULE8: apply at next cell start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eq_act_q       <= `LISC_RST_RX_EQ;
      pulse_act_q[0] <= 7'h00;
      pulse_act_q[1] <= 7'h00;
      pulse_act_q[2] <= 7'h00;
      pulse_act_q[3] <= 7'h00;
    end else if (sif.cell_start) begin
      eq_act_q       <= eq_reg_q;
      pulse_act_q[0] <= pulse_reg_q[0][6:0];
      pulse_act_q[1] <= pulse_reg_q[1][6:0];
      pulse_act_q[2] <= pulse_reg_q[2][6:0];
      pulse_act_q[3] <= pulse_reg_q[3][6:0];
    end
  end

  // ==========================================================
  // equalizer mode decode, mid-range takes priority over maximum
  logic eq_auto_disable;      // auto mode disable
  logic eq_single_stage_sel;  // one-stage select
  logic eq_double_stage_sel;  // two-stage select

  assign eq_auto_disable     = eq_act_q[`LISC_EQ_AUTO_DIS_BIT];
  assign eq_single_stage_sel = eq_act_q[`LISC_EQ_SINGLE_BIT];
  assign eq_double_stage_sel = eq_act_q[`LISC_EQ_DOUBLE_BIT];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eq_auto_en <= 1'b1;
      eq_mode    <= lisc_pkg::LISC_EQ_AUTO;
      eq_gain_db <= `LISC_GAIN_NONE_DB;
    end else if (!eq_auto_disable) begin
      // RULE2: automatic compensation stays on
      eq_auto_en <= 1'b1;
      eq_mode    <= lisc_pkg::LISC_EQ_AUTO;
      eq_gain_db <= `LISC_GAIN_NONE_DB;
    end else if (eq_single_stage_sel) begin
      // RULE3: forced single stage
      eq_auto_en <= 1'b0;
      eq_mode    <= lisc_pkg::LISC_EQ_SINGLE;
      eq_gain_db <= `LISC_GAIN_SINGLE_DB;
    end else if (eq_double_stage_sel) begin
      // RULE4: forced double stage
      eq_auto_en <= 1'b0;
      eq_mode    <= lisc_pkg::LISC_EQ_DOUBLE;
      eq_gain_db <= `LISC_GAIN_DOUBLE_DB;
    end else begin
      // RULE1: auto off, no stage forced
      eq_auto_en <= 1'b0;
      eq_mode    <= lisc_pkg::LISC_EQ_OFF;
      eq_gain_db <= `LISC_GAIN_NONE_DB;
    end
  end

  // ==========================================================
  // pulse coefficient of the current slot
  logic [6:0] cur_lvl;  // sign and magnitude for this slot
  always_comb begin
    cur_lvl = 7'h00;
    case (sif.slot)
      lisc_pkg::LISC_SLOT_ONE:   cur_lvl = pulse_act_q[0];
      lisc_pkg::LISC_SLOT_TWO:   cur_lvl = pulse_act_q[1];
      lisc_pkg::LISC_SLOT_THREE: cur_lvl = pulse_act_q[2];
      lisc_pkg::LISC_SLOT_FOUR:  cur_lvl = pulse_act_q[3];
      default:                   cur_lvl = 7'h00;
    endcase
  end

  logic [13:0] mag_mv;  // magnitude scaled to millivolts
  // RULE6: 100 mV per count
  assign mag_mv = {8'h00, cur_lvl[`LISC_PULSE_MAG_MSB:`LISC_PULSE_MAG_LSB]}
                  * `LISC_MV_PER_COUNT;

  // outputs registered; they trail the slot by one cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_slot       <= lisc_pkg::LISC_SLOT_FOUR;
      tx_cell_start <= 1'b0;
      tx_pulse_sign <= 1'b0;
      tx_pulse_mag  <= 6'h00;
      tx_pulse_mv   <= 14'sh0000;
    end else begin
      // RULE7: current slot coefficient
      tx_slot       <= sif.slot;
      tx_cell_start <= sif.cell_start;
      tx_pulse_mag  <= cur_lvl[`LISC_PULSE_MAG_MSB:`LISC_PULSE_MAG_LSB];
      // RULE5: sign one positive, zero negative
      tx_pulse_sign <= cur_lvl[`LISC_PULSE_SIGN_BIT];
      tx_pulse_mv   <= cur_lvl[`LISC_PULSE_SIGN_BIT] ? $signed(mag_mv)
                                                     : -$signed(mag_mv);
    end
  end

endmodule : lisc_top
